// ### pkg/fpcc_consts.svh
// Constants shared by both ends of the coprocessor command link.
// Assumes a single 40 MHz clock domain and word-wide command transfers.
//
// Functional notes
// - Nonsignaling predicates never set branch_unordered_flag.
// - Signaling predicates set flag when NAN set.
// - Evaluate the sixteen nonsignaling predicates exactly.
// - Evaluate the sixteen signaling predicates exactly.
// - Move control registers to and from operands.
// - Save exports state frame, restore reloads it.
// - Host computes addresses and moves all operands.
// - Device acts only on the command word.
// - Host rejects PC-relative destination operands.
// - Frames and field offsets grow by 32 bytes.
// - Unique format word; refuse predecessor frames.
// - Exception handlers save state before anything else.
// - Exception handlers set bus-unit flag bit 27.
// - Restore state before return_from_exception.
// - Plain interrupt handlers only save and restore.
// - Report predicate true or false to host.
// - Accept exactly 32 conditional test specifiers.
`ifndef FPCC_CONSTS_SVH
`define FPCC_CONSTS_SVH

// ****************************************************************
// Status and control register fields
// ****************************************************************
`define CC_N_BIT        27
`define CC_Z_BIT        26
`define CC_I_BIT        25
`define CC_NAN_BIT      24
`define BRANCH_UNORDERED_FLAG_BIT        15
`define BRANCH_UNORDERED_FLAG_EN_BIT     15
`define REG_RESET       32'h0000_0000

// ****************************************************************
// Register selectors carried in the command word
// ****************************************************************
`define SEL_CONTROL     5'h0_0
`define SEL_STATUS      5'h0_1
`define SEL_IADDR       5'h0_2

// ****************************************************************
// Frame layout, sizes and offsets in bytes, positions in 32-bit words
// ****************************************************************
`define PRED_FRAME_BYTES 24
`define FRAME_GROWTH     32
`define FRAME_BYTES      (`PRED_FRAME_BYTES + `FRAME_GROWTH)
`define FRAME_WORDS      4'h0_E
`define FRAME_LAST       4'h0_D
`define PRED_EXC_OP_OFF  4
`define EXC_OP_WORD      4'h0_9
`define OPREG_WORD       4'h0_C
`define BIU_WORD         4'h0_D
`define BIU_PEND_BIT     27
`define FMT_WORD         32'h5A38_0000
`define PRED_FMT_WORD    32'h1F18_0000

`endif

// ### pkg/fpcc_pkg.sv
// Types shared by both ends of the coprocessor command link.
// Assumes the constants header is included alongside.
package fpcc_pkg;

  typedef enum logic [2:0] {
    OP_COND    = 3'h0,
    OP_WR_REG  = 3'h1,
    OP_RD_REG  = 3'h2,
    OP_SAVE    = 3'h3,
    OP_RESTORE = 3'h4
  } cmd_op_t;

  typedef enum logic [1:0] {
    HK_NONE = 2'h0,
    HK_FPX  = 2'h1,
    HK_IRQ  = 2'h2
  } hdl_kind_t;

  typedef logic [13:0][31:0] frame_t;
  typedef logic [12:0][31:0] body_t;

endpackage

// ### pkg/fpcc_if.sv
// Command link between the host processor and the coprocessor.
// Assumes both ends share clk; the testbench instantiates and wires it.
`timescale 1ns/1ps
interface fpcc_if;
  import fpcc_pkg::*;

  logic            cmd_valid;
  logic            cmd_ready;
  cmd_op_t         cmd_op;
  logic     [4:0]  cmd_sel;
  logic     [31:0] cmd_data;
  logic            rsp_valid;
  logic     [31:0] rsp_data;
  logic            rsp_true;
  logic            rsp_last;
  logic            rsp_err;
  logic            rsp_exc;

  modport dev (
    input  cmd_valid, cmd_op, cmd_sel, cmd_data,
    output cmd_ready, rsp_valid, rsp_data, rsp_true, rsp_last, rsp_err, rsp_exc
  );

  modport host (
    output cmd_valid, cmd_op, cmd_sel, cmd_data,
    input  cmd_ready, rsp_valid, rsp_data, rsp_true, rsp_last, rsp_err, rsp_exc
  );
endinterface

// ### logic/fp_cond_device.sv
// Coprocessor end: predicate evaluation, control register moves and
// state save and restore, all driven by command words from the host.
// Assumes the host keeps cmd_* stable while cmd_valid waits for cmd_ready.
`timescale 1ns/1ps
`include "fpcc_consts.svh"
module fp_cond_device
  import fpcc_pkg::*;
(
  input  wire logic clk,
  input  wire logic arst_n,
  fpcc_if.dev       link,
  output logic      [31:0] control_reg,
  output logic      [31:0] status_reg,
  output logic      [31:0] iaddr_reg,
  output logic             busy
);

  // ****************************************************************
  // State
  // ****************************************************************
  typedef enum logic [1:0] {
    D_IDLE    = 2'b00,
    D_SAVE    = 2'b01,
    D_RESTORE = 2'b11
  } dev_st_t;

  typedef struct packed {
    dev_st_t      st;
    logic [31:0]  fp_control_registers;
    logic [31:0]  fpsr;
    logic [31:0]  fpiar;
    body_t        body;
    logic [3:0]   idx;
    logic         rsp_valid;
    logic [31:0]  rsp_data;
    logic         rsp_true;
    logic         rsp_last;
    logic         rsp_err;
    logic         rsp_exc;
  } dev_state_t;

  dev_state_t q;
  dev_state_t d;

  // ****************************************************************
  // Predicate evaluation
  // ****************************************************************
  // The low four selector bits pick the relation; bit 4 only marks the
  // signaling variant, so both halves share one table.
  // Unordered handling rule.
  // A set NAN code forces the ordered terms false and the unordered-inclusive
  // terms true through explicit nan factors, except codes 1 and E, which read z alone, and 3 and 5, whose z term is not masked by nan.
  function automatic logic pred_eval(input logic [3:0] code,
                                     input logic       n,
                                     input logic       z,
                                     input logic       nan);
    logic r;
    r = 1'b0;
    case (code)
      4'h0: r = 1'b0;
      4'h1: r = z;
      4'h2: r = ~(nan | z | n);
      4'h3: r = z | ~(nan | n);
      4'h4: r = n & ~(nan | z);
      4'h5: r = z | (n & ~nan);
      4'h6: r = ~(nan | z);
      4'h7: r = ~nan;
      4'h8: r = nan;
      4'h9: r = nan | z;
      4'hA: r = nan | ~(n | z);
      4'hB: r = nan | z | ~n;
      4'hC: r = nan | (n & ~z);
      4'hD: r = nan | z | n;
      4'hE: r = ~z;
      4'hF: r = 1'b1;
      default: r = 1'b0;
    endcase
    return r;
  endfunction

  logic pred_true;
  logic nan_now;
  logic signaling;

  always_comb begin
    nan_now   = q.fpsr[`CC_NAN_BIT];
    signaling = link.cmd_sel[4];
    pred_true = pred_eval(link.cmd_sel[3:0], q.fpsr[`CC_N_BIT],
                          q.fpsr[`CC_Z_BIT], nan_now);
  end

  // ****************************************************************
  // Command handling
  // ****************************************************************
  always_comb begin
    d           = q;
    d.rsp_valid = 1'b0;
    d.rsp_last  = 1'b0;
    d.rsp_err   = 1'b0;
    d.rsp_exc   = 1'b0;
    case (q.st)
      D_IDLE: begin
        // Command word only.
        // Nothing about how the host formed its operand address reaches
        // this end; op, selector and data are the whole request.
        if (link.cmd_valid) begin
          case (link.cmd_op)
            OP_COND: begin
              d.rsp_valid = 1'b1;
              d.rsp_true  = pred_true;
              d.rsp_data  = `REG_RESET;
              if (signaling && nan_now) begin
                d.fpsr[`BRANCH_UNORDERED_FLAG_BIT] = 1'b1;
                d.body[`OPREG_WORD - 4'h1] = {27'h000_0000, link.cmd_sel};
                // An enabled unordered trap is raised to the host now so
                // that its handler starts before the next instruction.
                if (q.fp_control_registers[`BRANCH_UNORDERED_FLAG_EN_BIT]) begin
                  d.rsp_exc = 1'b1;
                  d.body[`BIU_WORD - 4'h1][`BIU_PEND_BIT] = 1'b1;
                end
              end
            end
            OP_WR_REG: begin
              d.rsp_valid = 1'b1;
              d.rsp_data  = `REG_RESET;
              if (link.cmd_sel == `SEL_CONTROL) begin
                d.fp_control_registers = link.cmd_data;
              end else if (link.cmd_sel == `SEL_STATUS) begin
                d.fpsr = link.cmd_data;
              end else if (link.cmd_sel == `SEL_IADDR) begin
                d.fpiar = link.cmd_data;
              end else begin
                d.rsp_err = 1'b1;
              end
            end
            OP_RD_REG: begin
              d.rsp_valid = 1'b1;
              if (link.cmd_sel == `SEL_CONTROL) begin
                d.rsp_data = q.fp_control_registers;
              end else if (link.cmd_sel == `SEL_STATUS) begin
                d.rsp_data = q.fpsr;
              end else if (link.cmd_sel == `SEL_IADDR) begin
                d.rsp_data = q.fpiar;
              end else begin
                d.rsp_data = `REG_RESET;
                d.rsp_err  = 1'b1;
              end
            end
            OP_SAVE: begin
              d.st  = D_SAVE;
              d.idx = 4'h0;
            end
            OP_RESTORE: begin
              // Format word check.
              // Only our own format is taken; the predecessor's word, or
              // any other, is refused before a single body word lands.
              if (link.cmd_data == `FMT_WORD) begin
                d.st  = D_RESTORE;
                d.idx = 4'h1;
              end else begin
                d.rsp_valid = 1'b1;
                d.rsp_last  = 1'b1;
                d.rsp_err   = 1'b1;
                d.rsp_data  = link.cmd_data;
              end
            end
            default: begin
              d.rsp_valid = 1'b1;
              d.rsp_err   = 1'b1;
              d.rsp_data  = `REG_RESET;
            end
          endcase
        end
      end
      D_SAVE: begin
        // Enlarged frame stream.
        // Word 0 is the format word; the body follows with the exceptional
        // operand, operand register word and bus-unit word at their
        // shifted places.
        d.rsp_valid = 1'b1;
        if (q.idx == 4'h0) begin
          d.rsp_data = `FMT_WORD;
        end else begin
          d.rsp_data = q.body[4'(q.idx - 4'h1)];
        end
        d.idx = 4'(q.idx + 4'h1);
        if (q.idx == `FRAME_LAST) begin
          d.rsp_last = 1'b1;
          d.st       = D_IDLE;
          d.idx      = 4'h0;
        end
      end
      D_RESTORE: begin
        if (link.cmd_valid) begin
          d.body[4'(q.idx - 4'h1)] = link.cmd_data;
          d.idx = 4'(q.idx + 4'h1);
          if (q.idx == `FRAME_LAST) begin
            d.rsp_valid = 1'b1;
            d.rsp_last  = 1'b1;
            d.rsp_data  = `REG_RESET;
            d.st        = D_IDLE;
            d.idx       = 4'h0;
          end
        end
      end
      default: begin
        d.st = D_IDLE;
      end
    endcase
  end

  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      q <= '0;
    end else begin
      q <= d;
    end
  end

  // ****************************************************************
  // Outputs
  // ****************************************************************
  // A save streams without back-pressure, so no new command is taken
  // until its last word has gone out.
  assign link.cmd_ready = (q.st != D_SAVE);
  assign link.rsp_valid = q.rsp_valid;
  assign link.rsp_data  = q.rsp_data;
  assign link.rsp_true  = q.rsp_true;
  assign link.rsp_last  = q.rsp_last;
  assign link.rsp_err   = q.rsp_err;
  assign link.rsp_exc   = q.rsp_exc;
  assign control_reg    = q.fp_control_registers;
  assign status_reg     = q.fpsr;
  assign iaddr_reg      = q.fpiar;
  assign busy           = (q.st != D_IDLE);

endmodule

// ### logic/fp_host_end.sv
// Host end: turns user requests into command words and runs the
// save and restore steps that floating-point handlers need.
// Assumes user inputs come from logic on clk.
`timescale 1ns/1ps
`include "fpcc_consts.svh"
module fp_host_end
  import fpcc_pkg::*;
(
  input  wire logic clk,
  input  wire logic arst_n,
  fpcc_if.host      link,
  input  wire logic usr_valid,
  output logic      usr_ready,
  input  cmd_op_t   usr_op,
  input  wire logic [4:0]  usr_sel,
  input  wire logic [31:0] usr_data,
  input  wire logic usr_dst_pc_rel,
  output logic      usr_done,
  output logic      [31:0] usr_rdata,
  output logic      usr_true,
  output logic      usr_err,
  output logic      usr_exc,
  input  wire logic hdl_enter,
  input  hdl_kind_t hdl_kind,
  input  wire logic hdl_leave,
  output logic      hdl_busy,
  output logic      rte_go
);

  typedef enum logic [2:0] {
    H_IDLE = 3'b000,
    H_CMD  = 3'b001,
    H_WAIT = 3'b011,
    H_SAVE = 3'b010,
    H_RST  = 3'b110
  } host_st_t;

  typedef struct packed {
    host_st_t    st;
    hdl_kind_t   kind;
    logic        in_hdl;
    logic [3:0]  idx;
    frame_t      frame;
    logic        cmd_valid;
    cmd_op_t     cmd_op;
    logic [4:0]  cmd_sel;
    logic [31:0] cmd_data;
    logic        done;
    logic [31:0] rdata;
    logic        rtrue;
    logic        err;
    logic        exc;
    logic        return_from_exception;
  } host_state_t;

  host_state_t q;
  host_state_t d;
  logic        hdl_pending;

  // ****************************************************************
  // Sequencer
  // ****************************************************************
  always_comb begin
    hdl_pending = (hdl_enter && !q.in_hdl) || (hdl_leave && q.in_hdl);
    d      = q;
    d.done = 1'b0;
    d.return_from_exception  = 1'b0;
    d.err  = 1'b0;
    d.exc  = 1'b0;
    case (q.st)
      H_IDLE: begin
        if (hdl_enter && !q.in_hdl) begin
          d.in_hdl = 1'b1;
          d.kind   = hdl_kind;
          if (hdl_kind != HK_NONE) begin
            d.st        = H_SAVE;
            d.idx       = 4'h0;
            d.cmd_valid = 1'b1;
            d.cmd_op    = OP_SAVE;
            d.cmd_sel   = 5'h0_0;
            d.cmd_data  = 32'h0000_0000;
          end
        end else if (hdl_leave && q.in_hdl) begin
          if (q.kind == HK_NONE) begin
            d.in_hdl = 1'b0;
            d.return_from_exception    = 1'b1;
          end else begin
            d.st        = H_RST;
            d.idx       = 4'h0;
            d.cmd_valid = 1'b1;
            d.cmd_op    = OP_RESTORE;
            d.cmd_data  = q.frame[0];
          end
        end else if (usr_valid) begin
          if (usr_op == OP_RD_REG && usr_dst_pc_rel) begin
            d.done = 1'b1;
            d.err  = 1'b1;
          end else begin
            d.st        = H_CMD;
            d.cmd_valid = 1'b1;
            d.cmd_op    = usr_op;
            d.cmd_sel   = usr_sel;
            d.cmd_data  = usr_data;
          end
        end
      end
      H_CMD: begin
        if (link.cmd_ready) begin
          d.cmd_valid = 1'b0;
          d.st        = H_WAIT;
        end
      end
      H_WAIT: begin
        if (link.rsp_valid) begin
          d.done  = 1'b1;
          d.rdata = link.rsp_data;
          d.rtrue = link.rsp_true;
          d.err   = link.rsp_err;
          d.exc   = link.rsp_exc;
          d.st    = H_IDLE;
        end
      end
      H_SAVE: begin
        if (link.cmd_ready) begin
          d.cmd_valid = 1'b0;
        end
        if (link.rsp_valid) begin
          d.frame[q.idx] = link.rsp_data;
          d.idx = 4'(q.idx + 4'h1);
          if (link.rsp_last) begin
            if (q.kind == HK_FPX) begin
              d.frame[`BIU_WORD][`BIU_PEND_BIT] = 1'b1;
            end
            d.st  = H_IDLE;
            d.idx = 4'h0;
          end
        end
      end
      H_RST: begin
        if (q.cmd_valid && link.cmd_ready) begin
          d.idx = 4'(q.idx + 4'h1);
          if (q.idx == `FRAME_LAST) begin
            d.cmd_valid = 1'b0;
          end else begin
            d.cmd_data = q.frame[4'(q.idx + 4'h1)];
          end
        end
        // A refused frame also ends the handler; the error shows on usr_err for one cycle.
        if (link.rsp_valid) begin
          d.cmd_valid = 1'b0;
          d.in_hdl    = 1'b0;
          d.return_from_exception       = 1'b1;
          d.err       = link.rsp_err;
          d.st        = H_IDLE;
          d.idx       = 4'h0;
        end
      end
      default: begin
        d.st = H_IDLE;
      end
    endcase
  end

  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      q <= '0;
    end else begin
      q <= d;
    end
  end

  assign usr_ready      = (q.st == H_IDLE) && !hdl_pending;
  assign link.cmd_valid = q.cmd_valid;
  assign link.cmd_op    = q.cmd_op;
  assign link.cmd_sel   = q.cmd_sel;
  assign link.cmd_data  = q.cmd_data;
  assign usr_done       = q.done;
  assign usr_rdata      = q.rdata;
  assign usr_true       = q.rtrue;
  assign usr_err        = q.err;
  assign usr_exc        = q.exc;
  assign hdl_busy       = q.in_hdl;
  assign rte_go         = q.return_from_exception;

endmodule

// ### sim/fpcc_link_sva.sv
// Concurrent checks on the command link between host end and device end.
// Assumes one clock domain and the interface signals wired in by name.
`timescale 1ns/1ps
`include "fpcc_consts.svh"
module fpcc_link_sva
  import fpcc_pkg::*;
(
  input wire logic        clk,
  input wire logic        arst_n,
  input wire logic        cmd_valid,
  input wire logic        cmd_ready,
  input cmd_op_t          cmd_op,
  input wire logic [4:0]  cmd_sel,
  input wire logic [31:0] cmd_data,
  input wire logic        rsp_valid,
  input wire logic [31:0] rsp_data,
  input wire logic        rsp_last,
  input wire logic        rsp_err,
  input wire logic        rsp_exc
);
  // ****************************************************************
  // Helper logic and properties
  // ****************************************************************
  logic [3:0] body_q;
  logic       take;
  logic       idle_take;
  assign take      = cmd_valid && cmd_ready;
  assign idle_take = take && (body_q == 4'h0);
  // Restore body words carry any op code, so they must not be read as commands.
  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      body_q <= 4'h0;
    end else if (take && body_q != 4'h0) begin
      body_q <= body_q - 4'h1;
    end else if (idle_take && cmd_op == OP_RESTORE && cmd_data == `FMT_WORD) begin
      body_q <= 4'hD;
    end
  end
  default clocking cb @(posedge clk); endclocking
  default disable iff (!arst_n);
  sequence s_save_body;
    (rsp_valid && !cmd_ready && !rsp_last) [*8] ##1 (rsp_valid && !cmd_ready && !rsp_last) [*5];
  endsequence
  // The first save word is registered one cycle after the take, so a quiet
  // cycle comes first, and ready is back by the time the last word shows.
  sequence s_save_gap;
    !rsp_valid && !cmd_ready;
  endsequence
  sequence s_save_end;
    rsp_valid && rsp_last && cmd_ready;
  endsequence
  property p_cond_answer;
    idle_take && cmd_op == OP_COND |=> rsp_valid && !rsp_err;
  endproperty
  a_cond_answer: assert property (p_cond_answer)
    else $error("condition answer missing or flagged as error");
  property p_nonsig_quiet;
    idle_take && cmd_op == OP_COND && !cmd_sel[4] |=> !rsp_exc;
  endproperty
  a_nonsig_quiet: assert property (p_nonsig_quiet)
    else $error("nonsignaling test raised the unordered exception");
  property p_exc_cause;
    rsp_exc |-> $past(idle_take && cmd_op == OP_COND && cmd_sel[4]);
  endproperty
  a_exc_cause: assert property (p_exc_cause)
    else $error("unordered exception without a signaling test");
  property p_save_stream;
    idle_take && cmd_op == OP_SAVE |=> s_save_gap ##1 s_save_body ##1 s_save_end;
  endproperty
  a_save_stream: assert property (p_save_stream)
    else $error("save frame not fourteen back to back words");
  property p_save_format;
    idle_take && cmd_op == OP_SAVE |=> ##1 rsp_data == `FMT_WORD;
  endproperty
  a_save_format: assert property (p_save_format)
    else $error("save frame does not open with the format word");
  property p_refuse;
    idle_take && cmd_op == OP_RESTORE && cmd_data != `FMT_WORD
      |=> rsp_valid && rsp_last && rsp_err;
  endproperty
  a_refuse: assert property (p_refuse)
    else $error("foreign frame not refused");
  property p_restore_end;
    take && body_q == 4'h1 |=> rsp_valid && rsp_last && !rsp_err;
  endproperty
  a_restore_end: assert property (p_restore_end)
    else $error("restore end not reported");
  property p_bad_sel;
    idle_take && cmd_op inside {OP_RD_REG, OP_WR_REG} && cmd_sel > 5'h02 |=> rsp_valid && rsp_err;
  endproperty
  a_bad_sel: assert property (p_bad_sel)
    else $error("unknown register select accepted");
  property p_flags_qualified;
    rsp_err || rsp_last || rsp_exc |-> rsp_valid;
  endproperty
  a_flags_qualified: assert property (p_flags_qualified)
    else $error("answer flag without answer valid");
endmodule

// ### sim/fp_condition_and_state_save_tb.sv
// Testbench joining host end and device end over the command link.
// Assumes the constants header and package are compiled first.
`timescale 1ns/1ps
`include "fpcc_consts.svh"
module fp_condition_and_state_save_tb
  import fpcc_pkg::*;
;
  // ****************************************************************
  // Signals, instances and helpers
  // ****************************************************************
  logic        clk, arst_n, usr_valid, usr_ready, usr_dst_pc_rel, usr_done;
  logic        usr_true, usr_err, usr_exc, hdl_enter, hdl_leave, hdl_busy, rte_go, busy;
  logic [4:0]  usr_sel;
  logic [31:0] usr_data, usr_rdata, control_reg, status_reg, iaddr_reg, r_data;
  logic        r_true, r_err, r_exc, r_done;
  cmd_op_t     usr_op;
  hdl_kind_t   hdl_kind;
  int          miscompares = 0;
  int          comparisons = 0;
  fpcc_if link_if();
  fp_cond_device fp_cond_device_inst (.clk(clk), .arst_n(arst_n), .link(link_if),
    .control_reg(control_reg), .status_reg(status_reg), .iaddr_reg(iaddr_reg), .busy(busy));
  fp_host_end fp_host_end_inst (.clk(clk), .arst_n(arst_n), .link(link_if),
    .usr_valid(usr_valid), .usr_ready(usr_ready), .usr_op(usr_op), .usr_sel(usr_sel),
    .usr_data(usr_data), .usr_dst_pc_rel(usr_dst_pc_rel), .usr_done(usr_done),
    .usr_rdata(usr_rdata), .usr_true(usr_true), .usr_err(usr_err), .usr_exc(usr_exc),
    .hdl_enter(hdl_enter), .hdl_kind(hdl_kind), .hdl_leave(hdl_leave),
    .hdl_busy(hdl_busy), .rte_go(rte_go));
  fpcc_link_sva fpcc_link_sva_inst (.clk(clk), .arst_n(arst_n),
    .cmd_valid(link_if.cmd_valid), .cmd_ready(link_if.cmd_ready), .cmd_op(link_if.cmd_op),
    .cmd_sel(link_if.cmd_sel), .cmd_data(link_if.cmd_data), .rsp_valid(link_if.rsp_valid),
    .rsp_data(link_if.rsp_data), .rsp_last(link_if.rsp_last), .rsp_err(link_if.rsp_err),
    .rsp_exc(link_if.rsp_exc));
  always #12.5 clk = ~clk;
  task automatic check(input logic [31:0] seen, input logic [31:0] exp, input string what);
    comparisons++;
    if (seen !== exp) begin
      miscompares++;
      $display("[FAIL] %0t %s: seen %h expected %h", $time, what, seen, exp);
    end
  endtask
  task automatic conclude;
    $display("comparisons %0d miscompares %0d", comparisons, miscompares);
    if (miscompares == 0 && comparisons > 0) $display("Finished cleanly");
    else $display("Finished with errors");
    $finish;
  endtask
  // Bits of the code pick unordered, less, greater and equal in that order.
  function automatic logic pred(input logic [3:0] c, input logic n, z, nan);
    return (c[3] & nan) | (c[2] & !nan & !z & n) | (c[1] & !nan & !z & !n) | (c[0] & !nan & z);
  endfunction
  // Exception pulses come in the same cycle as done, so exc is sampled before done ends the wait.
  task automatic host_op(input cmd_op_t o, input logic [4:0] s, input logic [31:0] d,
                         input logic pc);
    int n;
    n = 0;
    // One edge always passes, so usr_valid never falls and rises in one time step.
    @(posedge clk);
    #2;
    while (usr_ready !== 1'b1 && n < 50) begin
      @(posedge clk);
      #2;
      n++;
    end
    usr_op = o; usr_sel = s; usr_data = d; usr_dst_pc_rel = pc; usr_valid = 1'b1;
    @(posedge clk);
    #2 usr_valid = 1'b0;
    r_exc = 1'b0;
    r_done = 1'b0;
    for (n = 0; n < 20 && !r_done; n++) begin
      if (usr_exc === 1'b1) r_exc = 1'b1;
      if (usr_done === 1'b1) begin
        r_done = 1'b1; r_data = usr_rdata; r_true = usr_true; r_err = usr_err;
      end else begin
        @(posedge clk);
        #2;
      end
    end
    check(r_done, 1, "no done");
  endtask
  // ****************************************************************
  // Scenarios
  // ****************************************************************
  task automatic t_regs;
    logic [31:0] v [0:2];
    int s;
    v[0] = 32'h0000_8000; v[1] = 32'h0800_0000; v[2] = 32'h1234_5678;
    check(control_reg | status_reg | iaddr_reg, 0, "reset value");
    check(link_if.cmd_ready, 1, "ready after reset");
    for (s = 0; s < 3; s++) begin
      host_op(OP_WR_REG, 5'(s), v[s], 1'b0);
      host_op(OP_RD_REG, 5'(s), 32'h0000_0000, 1'b0);
      check(r_data, v[s], "register readback");
      check(r_err, 0, "register error");
    end
    check(iaddr_reg, v[2], "address register");
    host_op(OP_RD_REG, 5'h03, 32'h0000_0000, 1'b0);
    check(r_err, 1, "unknown select");
  endtask
  task automatic t_preds;
    logic [31:0] cc [0:3];
    logic        f, p;
    int          c, s;
    cc[0] = 32'h0000_0000; cc[1] = 32'h0100_0000; cc[2] = 32'h0400_0000; cc[3] = 32'h0800_0000;
    for (c = 0; c < 4; c++) begin
      for (s = 0; s < 32; s++) begin
        host_op(OP_WR_REG, 5'h01, cc[c], 1'b0);
        host_op(OP_COND, 5'(s), 32'h0000_0000, 1'b0);
        f = s[4] & cc[c][24];
        p = pred(4'(s), cc[c][27], cc[c][26], cc[c][24]);
        check(r_true, p, "test");
        check(status_reg[15], f, "unordered flag");
        check(r_exc, f, "unordered exception");
        check(r_err, 0, "test code refused");
      end
    end
  endtask
  task automatic t_pcrel;
    host_op(OP_WR_REG, 5'h02, 32'h0055_AA00, 1'b1);
    check(r_err, 0, "pc relative source");
    host_op(OP_RD_REG, 5'h02, 32'h0000_0000, 1'b1);
    check(r_err, 1, "pc relative destination");
    host_op(OP_RD_REG, 5'h02, 32'h0000_0000, 1'b0);
    check(r_data, 32'h0055_AA00, "address readback");
  endtask
  task automatic t_refuse;
    host_op(OP_RESTORE, 5'h00, `PRED_FMT_WORD, 1'b0);
    check(r_err, 1, "old frame accepted");
    check(busy, 0, "busy after refusal");
  endtask
  task automatic t_handler(input hdl_kind_t k);
    logic [31:0] frm [0:15];
    logic [31:0] back;
    int          nw, nl, nt, i;
    logic        return_from_exception;
    nw = 0; nl = 0; nt = 0; return_from_exception = 1'b0; back = 32'h0000_0000;
    hdl_kind = k; hdl_enter = 1'b1;
    @(posedge clk);
    #2 hdl_enter = 1'b0;
    check(hdl_busy, 1, "handler flag");
    for (i = 0; i < 40; i++) begin
      if (link_if.rsp_valid === 1'b1) begin
        if (nw < 16) frm[nw] = link_if.rsp_data;
        nw++;
        if (link_if.rsp_last === 1'b1) nl = nw;
      end
      @(posedge clk);
      #2;
    end
    check(32'(nw), (k == HK_NONE) ? 0 : 14, "save words");
    if (nw == 14) begin
      check(frm[0], `FMT_WORD, "frame format");
      check(32'(nl), 14, "last save word");
    end
    hdl_leave = 1'b1;
    @(posedge clk);
    #2 hdl_leave = 1'b0;
    for (i = 0; i < 60 && !return_from_exception; i++) begin
      if (rte_go === 1'b1) return_from_exception = 1'b1;
      else begin
        if (link_if.cmd_valid === 1'b1 && link_if.cmd_ready === 1'b1) begin
          if (nt == 13) back = link_if.cmd_data;
          nt++;
        end
        @(posedge clk);
        #2;
      end
    end
    check(return_from_exception, 1, "no return");
    check(32'(nt), (k == HK_NONE) ? 0 : 14, "restore words");
    check(busy, 0, "busy at return");
    check(hdl_busy, 0, "handler flag at return");
    // The host marks its own copy, so the mark shows in the words it restores.
    if (nt == 14) begin
      check(back[27], (k == HK_FPX) ? 1'b1 : frm[13][27], "pending bit");
    end
  endtask
  // ****************************************************************
  // Main sequence and watchdog
  // ****************************************************************
  initial begin
    clk = 1'b0; arst_n = 1'b0; usr_valid = 1'b0; usr_op = OP_COND; usr_sel = 5'h00;
    usr_data = 32'h0000_0000; usr_dst_pc_rel = 1'b0; hdl_enter = 1'b0; hdl_kind = HK_NONE;
    hdl_leave = 1'b0;
    repeat (8) @(posedge clk);
    #2 arst_n = 1'b1;
    t_regs();
    t_preds();
    t_pcrel();
    t_refuse();
    t_handler(HK_FPX);
    t_handler(HK_IRQ);
    t_handler(HK_NONE);
    conclude();
  end
  // Whole run needs about twelve hundred cycles; the forty thousand allowed are over thirty times more.
  initial begin
    #1_000_000;
    miscompares++;
    conclude();
  end
endmodule
